// ==== src/sss_pkg.sv ====
package sss_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_TX_SYNC_HOLDING = 8'h00;
  localparam logic [7:0] OFF_RX_COMPARE_ZERO = 8'h04;
  localparam logic [7:0] OFF_RX_COMPARE_ONE = 8'h08;
  localparam logic [7:0] OFF_EVENT_STATUS = 8'h0C;
  localparam logic [7:0] OFF_IRQ_ENABLE_SET = 8'h10;
  localparam logic [7:0] OFF_IRQ_ENABLE_CLEAR = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h18;

  // status bit positions
  localparam int NUM_FLAGS = 12;
  localparam int POS_TX_HOLDING_FREE = 0;
  localparam int POS_TX_ALL_SENT = 1;
  localparam int POS_TX_DMA_COUNT_DONE = 2;
  localparam int POS_TX_DMA_BUFFERS_EMPTY = 3;
  localparam int POS_RX_WORD_AVAILABLE = 4;
  localparam int POS_RX_OVERWRITE = 5;
  localparam int POS_RX_DMA_COUNT_DONE = 6;
  localparam int POS_RX_DMA_BUFFERS_FULL = 7;
  localparam int POS_COMPARE_MATCH_ZERO = 8;
  localparam int POS_COMPARE_MATCH_ONE = 9;
  localparam int POS_TX_FRAME_SYNC_SEEN = 10;
  localparam int POS_RX_FRAME_SYNC_SEEN = 11;
  localparam int POS_TX_ENABLED_STATE = 16;
  localparam int POS_RX_ENABLED_STATE = 17;

  // field widths and reset values
  localparam int SYNC_WORD_W = 16;
  localparam int COMPARE_W = 16;
  localparam logic [15:0] RST_SYNC_WORD = 16'h0000;
  localparam logic [15:0] RST_COMPARE = 16'h0000;
  localparam logic [11:0] RST_MASK = 12'h000;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // datapath and dma counter view
  typedef struct packed {
    logic tx_hold_full;
    logic tx_shifting;
    logic tx_dma_count_zero;
    logic tx_dma_next_zero;
    logic tx_dma_cnt_write;
    logic rx_load;
    logic rx_hold_read;
    logic rx_dma_count_zero;
    logic rx_dma_next_zero;
    logic rx_dma_cnt_write;
    logic compare_zero_hit;
    logic compare_one_hit;
    logic tx_sync_event;
    logic rx_sync_event;
    logic tx_enabled;
    logic rx_enabled;
  } sss_dp_t;

endpackage

// ==== src/sss_status_irq.sv ====
`timescale 1ns/1ps

module sss_status_irq
  import sss_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // axi4-lite write address and data
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic [2:0] i_awprot,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  // axi4-lite write response
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // axi4-lite read
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [ADDR_W-1:0] i_araddr,
  input wire logic [2:0] i_arprot,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // datapath and dma counter state
  input wire sss_dp_t i_dp,
  // frame sync data output
  input wire logic i_sync_data_output_on,
  input wire logic i_tx_frame_sync,
  input wire logic i_tx_bit_tick,
  output logic o_sync_data_bit,
  output logic o_sync_data_active,
  // compare values to receiver
  output logic [COMPARE_W-1:0] o_compare_zero,
  output logic [COMPARE_W-1:0] o_compare_one,
  // interrupt
  output logic o_irq
);

  ////////////////////////////////////////////////////////////
  // register storage

  logic [SYNC_WORD_W-1:0] tx_sync_word;
  logic [NUM_FLAGS-1:0] irq_mask;
  logic [NUM_FLAGS-1:0] flags;
  logic [31:0] event_status;

  // sticky flag state
  logic tx_dma_count_done;
  logic rx_word_available;
  logic rx_overwrite;
  logic rx_dma_count_done;
  logic rx_zero_prev;
  logic [3:0] sticky;
  logic [3:0] sticky_set;

  ////////////////////////////////////////////////////////////
  // axi write side

  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [31:0] strb_mask;

  function automatic logic hit(input logic [ADDR_W-1:0] addr,
                               input logic [7:0] off);
    hit = (addr[ADDR_W-1:2] == (ADDR_W-2)'(ADDR_W'(off) >> 2));
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] addr);
    mapped = hit(addr, OFF_TX_SYNC_HOLDING) || hit(addr, OFF_RX_COMPARE_ZERO) ||
             hit(addr, OFF_RX_COMPARE_ONE) || hit(addr, OFF_EVENT_STATUS) ||
             hit(addr, OFF_IRQ_ENABLE_SET) || hit(addr, OFF_IRQ_ENABLE_CLEAR) ||
             hit(addr, OFF_IRQ_MASK);
  endfunction

  // byte-strobe merge into a 16-bit register; upper write lanes are dropped
  function automatic logic [15:0] merge_half(input logic [15:0] cur,
                                             input logic [31:0] data,
                                             input logic [31:0] mask);
    merge_half = (cur & ~mask[15:0]) | (data[15:0] & mask[15:0]);
  endfunction

  assign o_awready = !aw_held && !o_bvalid;
  assign o_wready = !w_held && !o_bvalid;
  assign do_write = aw_held && w_held && !o_bvalid;
  assign strb_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (o_awready && i_awvalid) begin
      aw_held <= 1'b1;
      aw_addr <= i_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (o_wready && i_wvalid) begin
      w_held <= 1'b1;
      w_data <= i_wdata;
      w_strb <= i_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_bvalid <= 1'b0;
      o_bresp <= RESP_OKAY;
    end else if (do_write) begin
      o_bvalid <= 1'b1;
      o_bresp <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////
  // software-written registers

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      tx_sync_word <= RST_SYNC_WORD;
    end else if (do_write && hit(aw_addr, OFF_TX_SYNC_HOLDING)) begin
      tx_sync_word <= merge_half(tx_sync_word, w_data, strb_mask);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_compare_zero <= RST_COMPARE;
      o_compare_one <= RST_COMPARE;
    end else if (do_write) begin
      if (hit(aw_addr, OFF_RX_COMPARE_ZERO)) begin
        o_compare_zero <= merge_half(o_compare_zero, w_data, strb_mask);
      end
      if (hit(aw_addr, OFF_RX_COMPARE_ONE)) begin
        o_compare_one <= merge_half(o_compare_one, w_data, strb_mask);
      end
    end
  end

  logic [NUM_FLAGS-1:0] mask_bits;
  logic [NUM_FLAGS-1:0] next_irq_mask;

  assign mask_bits = w_data[NUM_FLAGS-1:0] & strb_mask[NUM_FLAGS-1:0];

  // set and clear are separate addresses, so one write never does both
  always_comb begin
    next_irq_mask = irq_mask;
    if (do_write && hit(aw_addr, OFF_IRQ_ENABLE_SET)) begin
      next_irq_mask = irq_mask | mask_bits;
    end
    if (do_write && hit(aw_addr, OFF_IRQ_ENABLE_CLEAR)) begin
      next_irq_mask = irq_mask & ~mask_bits;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      irq_mask <= RST_MASK;
    end else begin
      irq_mask <= next_irq_mask;
    end
  end

  ////////////////////////////////////////////////////////////
  // axi read side

  logic status_read;
  logic ar_take;

  assign o_arready = !o_rvalid;
  assign ar_take = o_arready && i_arvalid;
  assign status_read = ar_take && hit(i_araddr, OFF_EVENT_STATUS);

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_rvalid <= 1'b0;
      o_rresp <= RESP_OKAY;
    end else if (ar_take) begin
      o_rvalid <= 1'b1;
      o_rresp <= mapped(i_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (i_rready) begin
      o_rvalid <= 1'b0;
    end
  end

  // data moves only on a taken address, so it stands while rvalid waits
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_rdata <= 32'h0000_0000;
    end else if (ar_take) begin
      if (hit(i_araddr, OFF_TX_SYNC_HOLDING)) begin
        o_rdata <= {16'h0000, tx_sync_word};
      end else if (hit(i_araddr, OFF_RX_COMPARE_ZERO)) begin
        o_rdata <= {16'h0000, o_compare_zero};
      end else if (hit(i_araddr, OFF_RX_COMPARE_ONE)) begin
        o_rdata <= {16'h0000, o_compare_one};
      end else if (hit(i_araddr, OFF_EVENT_STATUS)) begin
        o_rdata <= event_status;
      end else if (hit(i_araddr, OFF_IRQ_MASK)) begin
        o_rdata <= {20'h0_0000, irq_mask};
      end else begin
        o_rdata <= 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // event flags; in every flag a new set beats a clear in the same cycle

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      tx_dma_count_done <= 1'b0;
    end else if (i_dp.tx_dma_count_zero) begin
      tx_dma_count_done <= 1'b1;
    end else if (i_dp.tx_dma_cnt_write) begin
      tx_dma_count_done <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      rx_word_available <= 1'b0;
    end else if (i_dp.rx_load) begin
      rx_word_available <= 1'b1;
    end else if (i_dp.rx_hold_read) begin
      rx_word_available <= 1'b0;
    end
  end

  // a read of the old word in the same cycle as the reload is no overrun
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      rx_overwrite <= 1'b0;
    end else if (i_dp.rx_load && rx_word_available && !i_dp.rx_hold_read) begin
      rx_overwrite <= 1'b1;
    end else if (status_read) begin
      rx_overwrite <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      rx_zero_prev <= 1'b1;
    end else begin
      rx_zero_prev <= i_dp.rx_dma_count_zero;
    end
  end

  // edge, not level: a counter parked at zero must not defeat a counter write
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      rx_dma_count_done <= 1'b0;
    end else if (i_dp.rx_dma_count_zero && !rx_zero_prev) begin
      rx_dma_count_done <= 1'b1;
    end else if (i_dp.rx_dma_cnt_write) begin
      rx_dma_count_done <= 1'b0;
    end
  end

  assign sticky_set = {i_dp.rx_sync_event, i_dp.tx_sync_event,
                       i_dp.compare_one_hit, i_dp.compare_zero_hit};

  generate
    for (genvar g = 0; g < 4; g++) begin : g_sticky
      always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
          sticky[g] <= 1'b0;
        end else if (sticky_set[g]) begin
          sticky[g] <= 1'b1;
        end else if (status_read) begin
          sticky[g] <= 1'b0;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////
  // status assembly and interrupt

  always_comb begin
    flags = '0;
    flags[POS_TX_HOLDING_FREE] = !i_dp.tx_hold_full;
    flags[POS_TX_ALL_SENT] = !i_dp.tx_hold_full && !i_dp.tx_shifting;
    flags[POS_TX_DMA_COUNT_DONE] = tx_dma_count_done;
    flags[POS_TX_DMA_BUFFERS_EMPTY] = i_dp.tx_dma_count_zero && i_dp.tx_dma_next_zero;
    flags[POS_RX_WORD_AVAILABLE] = rx_word_available;
    flags[POS_RX_OVERWRITE] = rx_overwrite;
    flags[POS_RX_DMA_COUNT_DONE] = rx_dma_count_done;
    flags[POS_RX_DMA_BUFFERS_FULL] = i_dp.rx_dma_count_zero && i_dp.rx_dma_next_zero;
    flags[POS_COMPARE_MATCH_ZERO] = sticky[0];
    flags[POS_COMPARE_MATCH_ONE] = sticky[1];
    flags[POS_TX_FRAME_SYNC_SEEN] = sticky[2];
    flags[POS_RX_FRAME_SYNC_SEEN] = sticky[3];
  end

  always_comb begin
    event_status = 32'h0000_0000;
    event_status[NUM_FLAGS-1:0] = flags;
    event_status[POS_TX_ENABLED_STATE] = i_dp.tx_enabled;
    event_status[POS_RX_ENABLED_STATE] = i_dp.rx_enabled;
  end

  // combinational so the line drops the cycle a flag or mask bit clears
  assign o_irq = |(flags & irq_mask);

  ////////////////////////////////////////////////////////////
  // frame sync data shifter, lsb first

  logic [SYNC_WORD_W-1:0] sync_shift;
  logic frame_sync_prev;

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      frame_sync_prev <= 1'b0;
    end else begin
      frame_sync_prev <= i_tx_frame_sync;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_sync_data_active <= 1'b0;
    end else begin
      o_sync_data_active <= i_sync_data_output_on && i_tx_frame_sync;
    end
  end

  // the first bit leaves on the frame sync edge itself, later bits on ticks
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      sync_shift <= '0;
      o_sync_data_bit <= 1'b0;
    end else if (i_tx_frame_sync && !frame_sync_prev) begin
      sync_shift <= tx_sync_word >> 1;
      o_sync_data_bit <= tx_sync_word[0];
    end else if (i_tx_frame_sync && i_tx_bit_tick) begin
      sync_shift <= sync_shift >> 1;
      o_sync_data_bit <= sync_shift[0];
    end
  end

endmodule

// ==== tb/sss_dp_model.sv ====
`timescale 1ns/1ps
module sss_dp_model
  import sss_pkg::*;
(
  // clock
  input wire logic i_ref_clk,
  // requested datapath and counter state
  input wire sss_dp_t i_req,
  output sss_dp_t o_dp
);
  // registered so every event launches just after an edge, one cycle wide
  always_ff @(posedge i_ref_clk) begin
    o_dp <= i_req;
  end
endmodule

// ==== tb/sss_status_irq_props.sv ====
`timescale 1ns/1ps
module sss_status_irq_props
  import sss_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // watched ports
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [ADDR_W-1:0] i_araddr,
  input wire logic o_rvalid,
  input wire logic i_rready,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0] o_rresp,
  input wire sss_dp_t i_dp,
  input wire logic i_sync_data_output_on,
  input wire logic i_tx_frame_sync,
  input wire logic o_sync_data_active,
  input wire logic o_irq
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  logic rd_st;
  logic rd_any;
  assign rd_any = i_arvalid && o_arready;
  assign rd_st = rd_any && i_araddr == OFF_EVENT_STATUS;
  ////////////////////
  chk_irq_after_rst: assert property ($fell(i_sys_rst) |-> !o_irq)
    else $error("irq high right after reset");
  chk_rdata_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data dropped before rready");
  chk_read_answer: assert property (rd_any |=> o_rvalid)
    else $error("no read answer one cycle after address");
  chk_unmapped_read: assert property (rd_any && i_araddr[ADDR_W-1:2] > 6 |=>
    o_rresp == RESP_SLVERR && o_rdata == '0)
    else $error("unmapped read not refused");
  chk_status_ro_zero: assert property (rd_st |=> o_rdata[31:18] == '0 && o_rdata[15:12] == '0)
    else $error("unused status bits not zero");
  chk_status_ready: assert property (rd_st |=> o_rdata[0] != $past(i_dp.tx_hold_full))
    else $error("holding free flag wrong");
  chk_status_enables: assert property (rd_st |=> o_rdata[16] == $past(i_dp.tx_enabled) &&
    o_rdata[17] == $past(i_dp.rx_enabled))
    else $error("enable state bits wrong");
  chk_sync_active: assert property (!$past(i_sys_rst) |-> o_sync_data_active ==
    ($past(i_sync_data_output_on) && $past(i_tx_frame_sync)))
    else $error("sync data active wrong");
  cover property (rd_st);
  cover property (o_irq);
  cover property (o_sync_data_active);
endmodule

// ==== tb/test_sync_serial_status_irq.sv ====
`timescale 1ns/1ps
module test_sync_serial_status_irq;
  import sss_pkg::*;
  logic clk, rst, awv, wv, brdy, arv, rrdy, awr, wr_r, bv, arr, rv;
  logic fs_on, fs, tick, sbit, sact, irq;
  logic [7:0] awa, ara;
  logic [31:0] wd, rd_d;
  logic [1:0] br, rr;
  logic [15:0] c0, c1;
  sss_dp_t req, dp;
  int err_total, checks_done;
  sss_dp_model i_sss_dp_model (.i_ref_clk(clk), .i_req(req), .o_dp(dp));
  sss_status_irq i_sss_status_irq (.i_ref_clk(clk), .i_sys_rst(rst),
    .i_awvalid(awv), .o_awready(awr), .i_awaddr(awa), .i_awprot(3'h0),
    .i_wvalid(wv), .o_wready(wr_r), .i_wdata(wd), .i_wstrb(4'hF),
    .o_bvalid(bv), .i_bready(brdy), .o_bresp(br), .i_arvalid(arv),
    .o_arready(arr), .i_araddr(ara), .i_arprot(3'h0), .o_rvalid(rv),
    .i_rready(rrdy), .o_rdata(rd_d), .o_rresp(rr), .i_dp(dp),
    .i_sync_data_output_on(fs_on), .i_tx_frame_sync(fs), .i_tx_bit_tick(tick),
    .o_sync_data_bit(sbit), .o_sync_data_active(sact), .o_compare_zero(c0),
    .o_compare_one(c1), .o_irq(irq));
  ////////////////////
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge clk);
    awv <= 1'b1; wv <= 1'b1; awa <= a; wd <= d; brdy <= 1'b1;
    while (pa || pw) begin
      @(posedge clk);
      if (pa && awr) begin
        pa = 1'b0;
        awv <= 1'b0;
      end
      if (pw && wr_r) begin
        pw = 1'b0;
        wv <= 1'b0;
      end
    end
    do @(posedge clk); while (!bv);
    brdy <= 1'b0;
    chk("bresp", {30'h0, br}, {30'h0, RESP_OKAY});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    @(posedge clk);
    arv <= 1'b1; ara <= a; rrdy <= 1'b1;
    do @(posedge clk); while (!arr);
    arv <= 1'b0;
    do @(posedge clk); while (!rv);
    rrdy <= 1'b0;
    chk("rdata", rd_d, e);
    chk("rresp", {30'h0, rr}, {30'h0, r});
  endtask
  // levels only; pulses go through ev so the design sees them for one edge
  task automatic lvl(input logic [15:0] v);
    @(posedge clk);
    req <= v;
    repeat (2) @(posedge clk);
  endtask
  // returns one edge after the design has latched the pulse
  task automatic ev(input logic [15:0] m);
    @(posedge clk);
    req <= req | m;
    @(posedge clk);
    req <= req & ~m;
    repeat (2) @(posedge clk);
  endtask
  task automatic st(input logic [31:0] e);
    rd(OFF_EVENT_STATUS, e, RESP_OKAY);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  ////////////////////
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    finish_test();
  end
  initial begin
    {rst, awv, wv, brdy, arv, rrdy, fs_on, fs, tick} = 9'h100;
    {awa, ara, wd, req, err_total, checks_done} = '0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(OFF_TX_SYNC_HOLDING, 32'h0, RESP_OKAY);
    rd(OFF_IRQ_MASK, 32'h0, RESP_OKAY);
    st(32'h0000_0003);
    rd(8'h1C, 32'h0, RESP_SLVERR);
    wr(OFF_TX_SYNC_HOLDING, 32'hFFFF_FFFF);
    rd(OFF_TX_SYNC_HOLDING, 32'h0000_FFFF, RESP_OKAY);
    wr(OFF_RX_COMPARE_ZERO, 32'h1234_ABCD);
    wr(OFF_RX_COMPARE_ONE, 32'h5678_0F0F);
    rd(OFF_RX_COMPARE_ZERO, 32'h0000_ABCD, RESP_OKAY);
    chk("cmp1", {16'h0, c1}, 32'h0000_0F0F);
    chk("cmp0", {16'h0, c0}, 32'h0000_ABCD);
    wr(OFF_EVENT_STATUS, 32'hFFFF_FFFF);
    st(32'h0000_0003);
    wr(OFF_IRQ_ENABLE_SET, 32'h0000_0F0C);
    wr(OFF_IRQ_ENABLE_SET, 32'h0);
    rd(OFF_IRQ_MASK, 32'h0000_0F0C, RESP_OKAY);
    chk("irq", {31'h0, irq}, 32'h0);
    wr(OFF_IRQ_ENABLE_SET, 32'h0000_0001);
    chk("irq", {31'h0, irq}, 32'h1);
    wr(OFF_IRQ_ENABLE_CLEAR, 32'h0000_07FF);
    wr(OFF_IRQ_ENABLE_CLEAR, 32'h0);
    rd(OFF_IRQ_MASK, 32'h0000_0800, RESP_OKAY);
    ev(16'h003C);
    chk("irq", {31'h0, irq}, 32'h1);
    st(32'h0000_0F03);
    st(32'h0000_0003);
    chk("irq", {31'h0, irq}, 32'h0);
    ev(16'h0400);
    st(32'h0000_0013);
    ev(16'h0400);
    st(32'h0000_0033);
    st(32'h0000_0013);
    ev(16'h0200);
    st(32'h0000_0003);
    lvl(16'h2000);
    st(32'h0000_0007);
    lvl(16'h3180);
    st(32'h0000_00CF);
    lvl(16'h3080);
    st(32'h0000_004F);
    ev(16'h0040);
    st(32'h0000_000F);
    lvl(16'h0000);
    st(32'h0000_0007);
    ev(16'h0800);
    st(32'h0000_0003);
    lvl(16'h8000);
    st(32'h0000_0000);
    lvl(16'h4003);
    st(32'h0003_0001);
    lvl(16'h0000);
    wr(OFF_TX_SYNC_HOLDING, 32'h0000_000A);
    @(posedge clk);
    fs_on <= 1'b1;
    fs <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    chk("sync bit", {31'h0, sbit}, 32'h0);
    for (int i = 1; i < 4; i++) begin
      @(posedge clk);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
      @(negedge clk);
      chk("sync bit", {31'h0, sbit}, {31'h0, i[0]});
    end
    chk("sync active", {31'h0, sact}, 32'h1);
    finish_test();
  end
endmodule

bind sss_status_irq sss_status_irq_props #(.ADDR_W(ADDR_W)) i_sss_status_irq_props (
  .i_ref_clk, .i_sys_rst, .i_arvalid, .o_arready, .i_araddr, .o_rvalid, .i_rready,
  .o_rdata, .o_rresp, .i_dp, .i_sync_data_output_on, .i_tx_frame_sync,
  .o_sync_data_active, .o_irq);
